// ==== timer_pkg.sv ====
package timer_pkg;

  // ----------------------------------------------------------------
  // register map (word indices; the byte address is the index shifted left by two)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONFIG   = 8'h30;
  localparam logic [7:0] IDX_ENABLE   = 8'h31;
  localparam logic [7:0] IDX_T0_RLD_L = 8'h34;
  localparam logic [7:0] IDX_T0_RLD_H = 8'h35;
  localparam logic [7:0] IDX_T0_CNT_L = 8'h36;
  localparam logic [7:0] IDX_T0_CNT_H = 8'h37;
  localparam logic [7:0] IDX_T1_RLD_L = 8'h38;
  localparam logic [7:0] IDX_T1_RLD_H = 8'h39;
  localparam logic [7:0] IDX_T1_CNT_L = 8'h3A;
  localparam logic [7:0] IDX_T1_CNT_H = 8'h3B;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h3C;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h3D;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h3E;

  localparam int          ADDR_W       = 10;
  localparam logic [7:0]  RST_DIV      = 8'h00;
  localparam logic [1:0]  RST_ENABLE   = 2'h0;
  localparam logic [31:0] RST_RELOAD   = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT    = 32'h0000_0000;
  localparam logic [1:0]  RST_IRQ      = 2'h0;
  localparam int          HALF_W       = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rld_wr_lo;
    logic        rld_wr_hi;
    logic        cnt_wr_lo;
    logic        cnt_wr_hi;
    logic [15:0] wdata;
  } timer_wr_t;

  typedef struct packed {
    logic [31:0] reload;
    logic [31:0] count;
  } timer_view_t;

  // byte address of a word index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  // replace one 16-bit half of a 32-bit word
  function automatic logic [31:0] put_half(input logic [31:0] w,
                                           input logic        hi,
                                           input logic [15:0] h);
    put_half = hi ? {h, w[15:0]} : {w[31:16], h};
  endfunction : put_half

endpackage : timer_pkg

// ==== reload_down_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module reload_down_counter
  import timer_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  run,
  input  wire logic  tick,
  input  wire timer_wr_t wr,
  output timer_view_t view,
  output logic       underflow
);

  logic [WIDTH-1:0] reload_q, reload_d;
  logic [WIDTH-1:0] count_q, count_d;
  logic        run_q, run_d;
  logic        uf_q, uf_d;

  // ----------------------------------------------------------------
  // next state: software writes win over counting in the same cycle
  // ----------------------------------------------------------------
  always_comb begin
    reload_d = reload_q;
    count_d  = count_q;
    run_d    = run;
    uf_d     = 1'b0;
    if (wr.rld_wr_lo) reload_d = put_half(reload_q, 1'b0, wr.wdata);
    if (wr.rld_wr_hi) reload_d = put_half(reload_q, 1'b1, wr.wdata);
    if (run && !run_q) begin
      count_d = reload_q;
    end else if (run && tick) begin
      if (count_q == '0) begin
        // reload makes the period c+1 ticks
        count_d = reload_q;
        uf_d    = 1'b1;
      end else begin
        count_d = count_q - 32'h0000_0001;
      end
    end
    if (wr.cnt_wr_lo) count_d = put_half(count_d, 1'b0, wr.wdata);
    if (wr.cnt_wr_hi) count_d = put_half(count_d, 1'b1, wr.wdata);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= RST_RELOAD;
      count_q  <= RST_COUNT;
      run_q    <= 1'b0;
      uf_q     <= 1'b0;
    end else begin
      reload_q <= reload_d;
      count_q  <= count_d;
      run_q    <= run_d;
      uf_q     <= uf_d;
    end
  end

  // one driver for the whole view, fields packed in struct order
  assign view = '{reload: reload_q, count: count_q};
  assign underflow   = uf_q;

endmodule : reload_down_counter
`default_nettype wire

// ==== dual_reload_down_timer.sv ====
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dual_reload_down_timer
  import timer_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_q, div_d;
  logic [DIV_W-1:0] pre_q, pre_d;
  logic             tick_q, tick_d;
  logic [1:0]       en_q, en_d;
  logic [1:0]       stat_q, stat_d;
  logic [1:0]       ien_q, ien_d;
  logic             irq_q, irq_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             ready_q, ready_d;
  logic             err_q, err_d;
  logic [1:0]       uf;
  timer_wr_t        wr0, wr1;
  timer_view_t      v0, v1;
  logic             wr_acc;
  logic             rd_acc;
  logic [ADDR_W-1:0] a;

  // byte address; upper address bits ignored, so the map repeats
  assign a      = paddr[ADDR_W-1:0];
  // one wait state: access completes on the edge where ready_q is high
  assign wr_acc = psel && penable && ready_q && pwrite;
  assign rd_acc = psel && penable && !ready_q && !pwrite;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // true when the decoded address is the byte address of word idx
  function automatic logic hits(input logic [ADDR_W-1:0] at, input logic [7:0] idx);
    hits = (at == byte_addr(idx));
  endfunction : hits

  // ----------------------------------------------------------------
  // shared prescaler
  // ----------------------------------------------------------------
  // >= rather than == so lowering the divider never skips a wrap
  always_comb begin
    tick_d = 1'b0;
    pre_d  = pre_q;
    if (pre_q >= div_q) begin
      pre_d  = '0;
      tick_d = 1'b1;
    end else begin
      pre_d = pre_q + 1'b1;
    end
  end

  // prescaler count and tick pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // write strobes toward the two counters
  // ----------------------------------------------------------------
  // halves share the data lines; only the strobe picks the word
  always_comb begin
    wr0           = '0;
    wr1           = '0;
    wr0.wdata     = pwdata[HALF_W-1:0];
    wr1.wdata     = pwdata[HALF_W-1:0];
    wr0.rld_wr_lo = wr_acc && hits(a, IDX_T0_RLD_L);
    wr0.rld_wr_hi = wr_acc && hits(a, IDX_T0_RLD_H);
    wr0.cnt_wr_lo = wr_acc && hits(a, IDX_T0_CNT_L);
    wr0.cnt_wr_hi = wr_acc && hits(a, IDX_T0_CNT_H);
    wr1.rld_wr_lo = wr_acc && hits(a, IDX_T1_RLD_L);
    wr1.rld_wr_hi = wr_acc && hits(a, IDX_T1_RLD_H);
    wr1.cnt_wr_lo = wr_acc && hits(a, IDX_T1_CNT_L);
    wr1.cnt_wr_hi = wr_acc && hits(a, IDX_T1_CNT_H);
  end

  // both timers share one tick, so equal settings stay in step
  reload_down_counter #(
    .WIDTH (32)
  ) u_timer0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (en_q[0]),
    .tick      (tick_q),
    .wr        (wr0),
    .view      (v0),
    .underflow (uf[0])
  );

  reload_down_counter #(
    .WIDTH (32)
  ) u_timer1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (en_q[1]),
    .tick      (tick_q),
    .wr        (wr1),
    .view      (v1),
    .underflow (uf[1])
  );

  // ----------------------------------------------------------------
  // control registers and interrupt status
  // ----------------------------------------------------------------
  // register writes land only on the edge that completes the access
  always_comb begin
    div_d = div_q;
    en_d  = en_q;
    ien_d = ien_q;
    stat_d = stat_q;
    if (wr_acc && hits(a, IDX_CONFIG)) div_d = pwdata[DIV_W-1:0];
    if (wr_acc && hits(a, IDX_ENABLE)) en_d = pwdata[1:0];
    if (wr_acc && hits(a, IDX_IRQ_EN)) ien_d = pwdata[1:0];
    if (wr_acc && hits(a, IDX_IRQ_CLR)) stat_d = stat_q & ~pwdata[1:0];
    // set after clear so a same-cycle underflow is kept
    stat_d = stat_d | uf;
    irq_d  = |(stat_d & ien_d);
  end

  // control, status and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= RST_DIV;
      en_q   <= RST_ENABLE;
      ien_q  <= RST_IRQ;
      stat_q <= RST_IRQ;
      irq_q  <= 1'b0;
    end else begin
      div_q  <= div_d;
      en_q   <= en_d;
      ien_q  <= ien_d;
      stat_q <= stat_d;
      irq_q  <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: ready one cycle into access, unmapped gives pslverr
  // ----------------------------------------------------------------
  // read data is taken in the first access cycle, shown in the second
  always_comb begin
    ready_d = psel && penable && !ready_q;
    rdata_d = rdata_q;
    err_d   = 1'b0;
    if (psel && penable && !ready_q) begin
      rdata_d = 32'h0000_0000;
      unique case (a)
        byte_addr(IDX_CONFIG):   rdata_d[DIV_W-1:0] = div_q;
        byte_addr(IDX_ENABLE):   rdata_d[1:0] = en_q;
        byte_addr(IDX_T0_RLD_L): rdata_d[15:0] = v0.reload[15:0];
        byte_addr(IDX_T0_RLD_H): rdata_d[15:0] = v0.reload[31:16];
        byte_addr(IDX_T0_CNT_L): rdata_d[15:0] = v0.count[15:0];
        byte_addr(IDX_T0_CNT_H): rdata_d[15:0] = v0.count[31:16];
        byte_addr(IDX_T1_RLD_L): rdata_d[15:0] = v1.reload[15:0];
        byte_addr(IDX_T1_RLD_H): rdata_d[15:0] = v1.reload[31:16];
        byte_addr(IDX_T1_CNT_L): rdata_d[15:0] = v1.count[15:0];
        byte_addr(IDX_T1_CNT_H): rdata_d[15:0] = v1.count[31:16];
        byte_addr(IDX_IRQ_STAT): rdata_d[1:0] = stat_q;
        byte_addr(IDX_IRQ_EN):   rdata_d[1:0] = ien_q;
        byte_addr(IDX_IRQ_CLR):  rdata_d = 32'h0000_0000; // write only
        default:                 err_d = 1'b1;
      endcase
    end
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a register
  // ----------------------------------------------------------------
  assign prdata  = rdata_q;
  assign pready  = ready_q;
  assign pslverr = err_q;
  assign irq     = irq_q;

  // bits the design never uses (upper paddr and pwdata bits, rd_acc), gathered to show they are unused
  logic unused_ok;
  assign unused_ok = ^{paddr[31:ADDR_W], pwdata[31:HALF_W], rd_acc};

endmodule : dual_reload_down_timer
`default_nettype wire

// ==== timer_chk_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_chk
  import timer_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic       map;
  logic       cfg;
  // ----------------------------------------
  // helper: decoded map and divider shadow
  // ----------------------------------------
  always_comb begin
    map   = paddr[9:6] == 4'h3 && !(paddr[5:2] inside {4'h2, 4'h3, 4'hF});
    cfg   = paddr[9:0] == {IDX_CONFIG, 2'b00};
    div_d = (pready && pwrite && cfg) ? pwdata[7:0] : div_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 8'h00;
    else div_q <= div_d;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence
  property p_wait; s_setup ##1 s_wait |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_phase; pready |-> psel && penable; endproperty
  property p_err; pready && !map |-> pslverr; endproperty
  property p_ok; pready && map |-> !pslverr; endproperty
  property p_zero; pready && !pwrite && !map |-> prdata == 32'h0; endproperty
  property p_half; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
  property p_div; pready && !pwrite && cfg |-> prdata == {24'h0, div_q}; endproperty
  property p_mask;
    pready && pwrite && paddr[9:0] == {IDX_IRQ_EN, 2'b00} && pwdata[1:0] == 2'h0
      |=> ##1 !irq [*3];
  endproperty
  a_wait:  assert property (p_wait) else $error("no answer after one wait");
  a_one:   assert property (p_one) else $error("ready held too long");
  a_phase: assert property (p_phase) else $error("ready outside access");
  a_err:   assert property (p_err) else $error("unmapped without error");
  a_ok:    assert property (p_ok) else $error("error on mapped place");
  a_zero:  assert property (p_zero) else $error("unmapped read not zero");
  a_half:  assert property (p_half) else $error("upper half not zero");
  a_div:   assert property (p_div) else $error("divider readback wrong");
  a_mask:  assert property (p_mask) else $error("masked irq still high");
endmodule : timer_chk
bind dual_reload_down_timer timer_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ==== dual_reload_down_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dual_reload_down_timer_tb
  import timer_pkg::*;
;
  typedef struct packed {logic [7:0] i; logic [31:0] w; logic [31:0] e; logic x;} row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, v;
  logic        pready, pslverr, irq;
  int          err_total = 0, n_tests = 0, cyc = 0, n;
  time         t0;
  row_t        rows[9] = '{'{IDX_CONFIG, 32'h1A5, 32'hA5, 0},
    '{IDX_T0_RLD_L, 32'h1234ABCD, 32'hABCD, 0}, '{IDX_T0_RLD_H, 32'hFFFF5678, 32'h5678, 0},
    '{IDX_T1_RLD_L, 32'h1, 32'h1, 0}, '{IDX_T1_RLD_H, 32'h8000, 32'h8000, 0},
    '{IDX_T1_CNT_L, 32'hC3, 32'hC3, 0}, '{IDX_T1_CNT_H, 32'h7E00, 32'h7E00, 0},
    '{IDX_IRQ_EN, 32'h3, 32'h3, 0}, '{8'h3F, 32'hFFFFFFFF, 32'h0, 1}};
  always #2.5 pclk = ~pclk;
  dual_reload_down_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wirq(output int k);
    for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
  endtask : wirq
  // hang guard; whole run is well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    apb(0, IDX_ENABLE, 0);
    chk(rd, 32'h0);
    apb(0, IDX_T0_CNT_L, 0);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (rows[k]) begin
      apb(1, rows[k].i, rows[k].w);
      apb(0, rows[k].i, 0);
      chk(rd, rows[k].e);
      chk({31'h0, er}, {31'h0, rows[k].x});
    end
    $display("register table done");
    apb(1, IDX_CONFIG, 2);
    apb(1, IDX_T0_RLD_L, 4);
    apb(1, IDX_T0_RLD_H, 0);
    apb(1, IDX_ENABLE, 1);
    apb(0, IDX_T0_CNT_L, 0);
    chk({31'h0, rd inside {32'h3, 32'h4}}, 32'h1);
    wirq(n);
    t0 = $time;
    apb(1, IDX_IRQ_CLR, 1);
    repeat (2) @(posedge pclk);
    wirq(n);
    chk(($time - t0) / 5, 32'd15);
    apb(1, IDX_IRQ_EN, 0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1, IDX_ENABLE, 0);
    apb(0, IDX_T0_CNT_L, 0);
    v = rd;
    repeat (20) @(posedge pclk);
    apb(0, IDX_T0_CNT_L, 0);
    chk(rd, v);
    apb(1, IDX_T0_CNT_L, 32'h9);
    apb(0, IDX_T0_CNT_L, 0);
    chk(rd, 32'h9);
    $display("timer zero test done");
    apb(1, IDX_IRQ_CLR, 3);
    apb(0, IDX_IRQ_STAT, 0);
    chk(rd, 32'h0);
    apb(1, IDX_T1_RLD_H, 0);
    apb(1, IDX_IRQ_EN, 2);
    apb(1, IDX_ENABLE, 2);
    wirq(n);
    chk({31'h0, irq}, 32'h1);
    apb(0, IDX_IRQ_STAT, 0);
    chk(rd, 32'h2);
    $display("timer one test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    apb(0, IDX_ENABLE, 0);
    chk(rd, 32'h0);
    apb(0, IDX_T1_RLD_L, 0);
    chk(rd, 32'h0);
    $display("mid-run reset test done");
    close_out();
  end
endmodule : dual_reload_down_timer_tb
`default_nettype wire
